// >>> pkg/sdcc_pkg.sv
package sdcc_pkg;
	// ***********************************************************
	// register map
	// ***********************************************************
	localparam logic [7:0]  OFS_MODE  = 8'h00;
	localparam logic [7:0]  OFS_RTIM  = 8'h04;
	localparam logic [7:0]  OFS_CFG   = 8'h08;
	localparam logic [7:0]  OFS_DEC   = 8'h0C;
	localparam logic [7:0]  OFS_LPR   = 8'h10;
	localparam logic [7:0]  OFS_IEN   = 8'h14;
	localparam logic [7:0]  OFS_IDIS  = 8'h18;
	localparam logic [7:0]  OFS_IMSK  = 8'h1C;
	localparam logic [7:0]  OFS_ISTA  = 8'h20;
	localparam logic [7:0]  OFS_MTYP  = 8'h24;
	localparam logic [31:0] RST_CFG   = 32'h852372C0;
	localparam logic [31:0] RST_ZERO  = 32'h00000000;
	localparam logic [13:0] LPR_WMASK = 14'h3F73;
	// ***********************************************************
	// field positions
	// ***********************************************************
	localparam int CF_NC   = 0;
	localparam int CF_NR   = 2;
	localparam int CF_NB   = 4;
	localparam int CF_CAS  = 5;
	localparam int CF_DBW  = 7;
	localparam int CF_TWR  = 8;
	localparam int CF_TRC  = 12;
	localparam int CF_TRP  = 16;
	localparam int CF_ACTIVATE_TO_ACCESS_CYCLES = 20;
	localparam int CF_ACTIVATE_TO_PRECHARGE_CYCLES = 24;
	localparam int LP_LOW_POWER_CONFIG = 0;
	localparam int LP_PARTIAL_ARRAY_REFRESH = 4;
	localparam int LP_TCSR = 8;
	localparam int LP_DS   = 10;
	localparam int LM_CAS  = 4;
	localparam int EM_TCSR = 3;
	localparam int EM_DS   = 5;
	localparam int AP_BIT  = 10;
	localparam int TR_W    = 12;
	localparam logic [3:0] NC_BASE  = 4'h8;
	localparam logic [3:0] NR_BASE  = 4'hB;
	localparam logic [1:0] LOW_POWER_CONFIG_DPD = 2'h3;
	localparam logic [1:0] BA_EMR   = 2'h2;
	// ***********************************************************
	// types
	// ***********************************************************
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h0,
		MODE_NOP    = 3'h1,
		MODE_PALL   = 3'h2,
		MODE_LMR    = 3'h3,
		MODE_AREF   = 3'h4,
		MODE_EMR    = 3'h5,
		MODE_DPD    = 3'h6
	} sdcc_mode_t;
	typedef enum logic [3:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PALL, CMD_LMR, CMD_EMR, CMD_AREF, CMD_DPD
	} sdcc_cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEC  = 3'b001,
		ST_RCD  = 3'b011,
		ST_XFR  = 3'b010,
		ST_PRE  = 3'b110,
		ST_REF  = 3'b100,
		ST_DPD  = 3'b101
	} sdcc_st_t;
endpackage

// >>> design/sdcc_refresh_timer.sv
`timescale 1ns/1ps
module sdcc_refresh_timer #(
	parameter int CW = 12
)
(
	input  wire logic          mclk,
	input  wire logic          srst,
	input  wire logic          ce,
	input  wire logic [CW-1:0] count,
	input  wire logic          count_wr,
	input  wire logic          ref_done,
	output logic               ref_req,
	output logic               ref_err
);
	typedef struct packed {
		logic          armed;
		logic [CW-1:0] cnt;
		logic          req;
		logic          err;
	} sdcc_rt_t;

	sdcc_rt_t s_q;
	sdcc_rt_t s_d;
	logic     tick;

	// period ends only once software has given a count
	assign tick = s_q.armed && (s_q.cnt == '0);

	// reload, count down, raise request; a new tick beats the done
	always_comb
	begin
		s_d     = s_q;
		s_d.err = tick && s_q.req && !ref_done;
		if (count_wr)
		begin
			s_d.armed = (count != '0);
			s_d.cnt   = count;
		end
		else if (s_q.armed)
			s_d.cnt = tick ? count : s_q.cnt - 1'b1;
		if (ref_done)
			s_d.req = 1'b0;
		if (tick)
			s_d.req = 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign ref_req = s_q.req;
	assign ref_err = s_q.err;

	// ***********************************************************
	// checks
	// ***********************************************************
	AST_RT_UNARMED: assert property (@(posedge mclk) disable iff (srst)
		!s_q.armed |-> !ref_req) else $error("refresh requested before count written");
	AST_RT_PULSE: assert property (@(posedge mclk) disable iff (srst)
		ce && tick |=> ref_req) else $error("timer expiry did not raise refresh");
	AST_RT_ERR: assert property (@(posedge mclk) disable iff (srst)
		ce && tick && ref_req && !ref_done |=> ref_err) else $error("missed refresh not flagged");
endmodule

// >>> design/sdcc_ctrl.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module sdcc_ctrl #(
	parameter int AW = 26
)
(
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire logic                 ce,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 acc_valid,
	input  wire logic                 acc_write,
	input  wire logic [AW-1:0]        acc_addr,
	output logic                      acc_done,
	input  wire logic                 sd_link_clk,
	output logic                      sd_cke,
	output sdcc_pkg::sdcc_cmd_t       sd_cmd,
	output logic      [1:0]           sd_bank,
	output logic      [12:0]          sd_addr,
	output logic      [3:0]           cfg_col_bits,
	output logic      [3:0]           cfg_row_bits,
	output logic                      cfg_bank4,
	output logic                      cfg_bus16,
	output logic      [1:0]           cfg_cas
);
	typedef struct packed {
		logic [2:0]          mode;
		logic [11:0]         rcnt;
		logic                rwr;
		logic [31:0]         cfg;
		logic                da;
		logic [13:0]         low_power_reg;
		logic [2:0]          mtyp;
		logic                msk;
		logic                res;
		logic [31:0]         rdat;
		logic                serr;
		logic                meta;
		logic                sync;
		logic                prev;
		sdcc_pkg::sdcc_st_t  st;
		logic [3:0]          wt;
		logic [3:0]          activate_to_precharge_cycles;
		logic [AW-1:0]       adr;
		logic                wr;
		logic                pend;
		sdcc_pkg::sdcc_cmd_t cmd;
		logic [1:0]          ba;
		logic [12:0]         a;
		logic                cke;
		logic                done;
		logic                rdone;
	} sdcc_state_t;

	sdcc_state_t   s_q;
	sdcc_state_t   s_d;
	logic          rise;
	logic          setup;
	logic          acc_ph;
	logic          hit;
	logic [31:0]   rd_v;
	logic          ref_req;
	logic          ref_err;
	logic [1:0]    low_power_config;
	logic [3:0]    write_recovery_cycles;
	logic [3:0]    refresh_to_activate_cycles;
	logic [3:0]    precharge_delay_cycles;
	logic [3:0]    activate_to_access_cycles;
	logic [3:0]    activate_to_precharge_cycles_v;
	logic [3:0]    ws;
	logic [3:0]    nbb;
	logic [AW-1:0] sh_col;
	logic [AW-1:0] sh_bank;
	logic [AW-1:0] sh_row;
	logic [12:0]   col_a;
	logic [12:0]   row_a;
	logic [1:0]    bank_a;

	// ***********************************************************
	// configuration decode
	// ***********************************************************
	assign cfg_col_bits = sdcc_pkg::NC_BASE + {2'h0, s_q.cfg[sdcc_pkg::CF_NC +: 2]};
	// reserved row code 3 yields 14, left undefined for software
	assign cfg_row_bits = sdcc_pkg::NR_BASE + {2'h0, s_q.cfg[sdcc_pkg::CF_NR +: 2]};
	assign cfg_bank4    = s_q.cfg[sdcc_pkg::CF_NB];
	assign cfg_cas      = s_q.cfg[sdcc_pkg::CF_CAS +: 2];
	assign cfg_bus16    = s_q.cfg[sdcc_pkg::CF_DBW];
	assign write_recovery_cycles          = s_q.cfg[sdcc_pkg::CF_TWR +: 4];
	assign refresh_to_activate_cycles          = s_q.cfg[sdcc_pkg::CF_TRC +: 4];
	assign precharge_delay_cycles          = s_q.cfg[sdcc_pkg::CF_TRP +: 4];
	assign activate_to_access_cycles         = s_q.cfg[sdcc_pkg::CF_ACTIVATE_TO_ACCESS_CYCLES +: 4];
	assign activate_to_precharge_cycles_v       = s_q.cfg[sdcc_pkg::CF_ACTIVATE_TO_PRECHARGE_CYCLES +: 4];
	assign low_power_config         = s_q.low_power_reg[sdcc_pkg::LP_LOW_POWER_CONFIG +: 2];

	// address split: column, then bank, then row above them
	assign ws      = cfg_bus16 ? 4'h1 : 4'h2;
	assign nbb     = cfg_bank4 ? 4'h2 : 4'h1;
	assign sh_col  = s_q.adr >> ws;
	assign sh_bank = sh_col >> cfg_col_bits;
	assign sh_row  = sh_bank >> nbb;
	assign col_a   = sh_col[12:0] & ~(13'h1FFF << cfg_col_bits);
	assign row_a   = sh_row[12:0] & ~(13'h1FFF << cfg_row_bits);
	assign bank_a  = sh_bank[1:0] & {cfg_bank4, 1'b1};

	// ***********************************************************
	// register bus
	// ***********************************************************
	assign setup  = psel && !penable;
	assign acc_ph = psel && penable;
	assign rise   = s_q.sync && !s_q.prev;

	// read mux; write-only words read as zero
	always_comb
	begin
		hit  = 1'b1;
		rd_v = sdcc_pkg::RST_ZERO;
		case (paddr)
			sdcc_pkg::OFS_MODE: rd_v[2:0] = s_q.mode;
			sdcc_pkg::OFS_RTIM: rd_v[11:0] = s_q.rcnt;
			sdcc_pkg::OFS_CFG:  rd_v = s_q.cfg;
			sdcc_pkg::OFS_DEC:  rd_v[0] = s_q.da;
			sdcc_pkg::OFS_LPR:  rd_v[13:0] = s_q.low_power_reg;
			sdcc_pkg::OFS_IEN:  rd_v[0] = 1'b0;
			sdcc_pkg::OFS_IDIS: rd_v[0] = 1'b0;
			sdcc_pkg::OFS_IMSK: rd_v[0] = s_q.msk;
			sdcc_pkg::OFS_ISTA: rd_v[0] = s_q.res;
			sdcc_pkg::OFS_MTYP: rd_v[2:0] = s_q.mtyp;
			default:            hit = 1'b0;
		endcase
	end

	// ***********************************************************
	// next state
	// ***********************************************************
	always_comb
	begin
		s_d       = s_q;
		s_d.rwr   = 1'b0;
		s_d.done  = 1'b0;
		s_d.rdone = 1'b0;
		// two-stage synchroniser on the memory clock pin
		s_d.meta  = sd_link_clk;
		s_d.sync  = s_q.meta;
		s_d.prev  = s_q.sync;
		// answer is prepared in setup so prdata comes from a flop
		if (setup)
		begin
			s_d.rdat = rd_v;
			s_d.serr = !hit;
		end
		// writes commit in the access phase; read-only words ignore them
		if (acc_ph && pwrite)
		begin
			case (paddr)
				sdcc_pkg::OFS_MODE: s_d.mode = pwdata[2:0];
				sdcc_pkg::OFS_RTIM:
				begin
					s_d.rcnt = pwdata[11:0];
					s_d.rwr  = 1'b1;
				end
				sdcc_pkg::OFS_CFG:  s_d.cfg = pwdata;
				sdcc_pkg::OFS_DEC:  s_d.da = pwdata[0];
				sdcc_pkg::OFS_LPR:  s_d.low_power_reg = pwdata[13:0] & sdcc_pkg::LPR_WMASK;
				sdcc_pkg::OFS_IEN:  s_d.msk = s_q.msk | pwdata[0];
				sdcc_pkg::OFS_IDIS: s_d.msk = s_q.msk & !pwdata[0];
				sdcc_pkg::OFS_MTYP: s_d.mtyp = pwdata[2:0];
				default:            s_d.mtyp = s_q.mtyp;
			endcase
		end
		// status read acknowledges; a new error in that cycle wins
		if (acc_ph && !pwrite && (paddr == sdcc_pkg::OFS_ISTA))
			s_d.res = 1'b0;
		if (ref_err)
			s_d.res = 1'b1;
		// command sequencer advances on memory clock rising edges only
		if (rise)
		begin
			s_d.cmd = sdcc_pkg::CMD_NOP;
			if (s_q.wt != 4'h0)
				s_d.wt = s_q.wt - 4'h1;
			if (s_q.activate_to_precharge_cycles != 4'h0)
				s_d.activate_to_precharge_cycles = s_q.activate_to_precharge_cycles - 4'h1;
			case (s_q.st)
				sdcc_pkg::ST_IDLE:
				begin
					// refresh is served before a waiting access
					if (ref_req)
					begin
						s_d.cmd   = sdcc_pkg::CMD_AREF;
						s_d.rdone = 1'b1;
						s_d.wt    = refresh_to_activate_cycles;
						s_d.st    = sdcc_pkg::ST_REF;
					end
					else if (acc_valid)
					begin
						s_d.adr  = acc_addr;
						s_d.wr   = acc_write;
						s_d.pend = 1'b1;
						case (sdcc_pkg::sdcc_mode_t'(s_q.mode))
							sdcc_pkg::MODE_NORMAL:
								s_d.st = sdcc_pkg::ST_DEC;
							sdcc_pkg::MODE_PALL:
							begin
								s_d.cmd = sdcc_pkg::CMD_PALL;
								s_d.a   = 13'h1 << sdcc_pkg::AP_BIT;
								s_d.wt  = precharge_delay_cycles;
								s_d.st  = sdcc_pkg::ST_PRE;
							end
							sdcc_pkg::MODE_LMR:
							begin
								s_d.cmd  = sdcc_pkg::CMD_LMR;
								s_d.a    = 13'(cfg_cas) << sdcc_pkg::LM_CAS;
								s_d.ba   = 2'h0;
								s_d.done = 1'b1;
								s_d.pend = 1'b0;
							end
							sdcc_pkg::MODE_AREF:
							begin
								// relies on software precharging beforehand
								s_d.cmd = sdcc_pkg::CMD_AREF;
								s_d.wt  = refresh_to_activate_cycles;
								s_d.st  = sdcc_pkg::ST_REF;
							end
							sdcc_pkg::MODE_EMR:
							begin
								s_d.cmd  = sdcc_pkg::CMD_EMR;
								s_d.a    = 13'(s_q.low_power_reg[sdcc_pkg::LP_PARTIAL_ARRAY_REFRESH +: 3])
									| (13'(s_q.low_power_reg[sdcc_pkg::LP_TCSR +: 2]) << sdcc_pkg::EM_TCSR)
									| (13'(s_q.low_power_reg[sdcc_pkg::LP_DS +: 2]) << sdcc_pkg::EM_DS);
								s_d.ba   = sdcc_pkg::BA_EMR;
								s_d.done = 1'b1;
								s_d.pend = 1'b0;
							end
							sdcc_pkg::MODE_DPD:
							begin
								s_d.cmd  = sdcc_pkg::CMD_DPD;
								s_d.cke  = 1'b0;
								s_d.st   = sdcc_pkg::ST_DPD;
								s_d.done = 1'b1;
								s_d.pend = 1'b0;
							end
							default:
							begin
								// NOP mode and the unused code just complete
								s_d.done = 1'b1;
								s_d.pend = 1'b0;
							end
						endcase
					end
					else if (low_power_config == sdcc_pkg::LOW_POWER_CONFIG_DPD)
					begin
						s_d.cmd = sdcc_pkg::CMD_DPD;
						s_d.cke = 1'b0;
						s_d.st  = sdcc_pkg::ST_DPD;
					end
				end
				sdcc_pkg::ST_DEC:
				begin
					// decode cycle spends one edge before activate, with da set or clear
					if (!s_q.da || s_q.wt == 4'h0)
					begin
						s_d.cmd  = sdcc_pkg::CMD_ACT;
						s_d.a    = row_a;
						s_d.ba   = bank_a;
						s_d.wt   = activate_to_access_cycles;
						s_d.activate_to_precharge_cycles = activate_to_precharge_cycles_v;
						s_d.st   = sdcc_pkg::ST_RCD;
					end
				end
				sdcc_pkg::ST_RCD:
				begin
					if (s_q.wt == 4'h0)
					begin
						s_d.cmd = s_q.wr ? sdcc_pkg::CMD_WR : sdcc_pkg::CMD_RD;
						s_d.a   = col_a;
						s_d.wt  = s_q.wr ? write_recovery_cycles : {2'h0, cfg_cas};
						s_d.st  = sdcc_pkg::ST_XFR;
					end
				end
				sdcc_pkg::ST_XFR:
				begin
					if (s_q.wt == 4'h0 && s_q.activate_to_precharge_cycles == 4'h0)
					begin
						s_d.cmd = sdcc_pkg::CMD_PALL;
						s_d.a   = 13'h1 << sdcc_pkg::AP_BIT;
						s_d.wt  = precharge_delay_cycles;
						s_d.st  = sdcc_pkg::ST_PRE;
					end
				end
				sdcc_pkg::ST_PRE, sdcc_pkg::ST_REF:
				begin
					// forced precharge and refresh finish only after their recovery time
					if (s_q.wt == 4'h0)
					begin
						s_d.done = s_q.pend;
						s_d.pend = 1'b0;
						s_d.st   = sdcc_pkg::ST_IDLE;
					end
				end
				sdcc_pkg::ST_DPD:
				begin
					// contents are gone; leave only once both selections drop
					if (low_power_config != sdcc_pkg::LOW_POWER_CONFIG_DPD && s_q.mode != sdcc_pkg::MODE_DPD)
					begin
						s_d.cke = 1'b1;
						s_d.st  = sdcc_pkg::ST_IDLE;
					end
				end
				default:
					s_d.st = sdcc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			s_q     <= '0;
			s_q.cfg <= sdcc_pkg::RST_CFG;
			s_q.cke <= 1'b1;
		end
		else if (ce)
			s_q <= s_d;
	end

	sdcc_refresh_timer #(
		.CW (sdcc_pkg::TR_W)
	) u_rtim (
		.mclk     (mclk),
		.srst     (srst),
		.ce       (ce),
		.count    (s_q.rcnt),
		.count_wr (s_q.rwr),
		.ref_done (s_q.rdone),
		.ref_req  (ref_req),
		.ref_err  (ref_err)
	);

	// ***********************************************************
	// outputs
	// ***********************************************************
	assign prdata   = s_q.rdat;
	assign pready   = 1'b1;
	assign pslverr  = acc_ph && s_q.serr;
	assign acc_done = s_q.done;
	assign sd_cke   = s_q.cke;
	assign sd_cmd   = s_q.cmd;
	assign sd_bank  = s_q.ba;
	assign sd_addr  = s_q.a;

	// ***********************************************************
	// checks
	// ***********************************************************
	logic                h_new;
	logic [4:0]          h_cnt;
	sdcc_pkg::sdcc_cmd_t h_last;
	logic                iss;

	// count NOP edges since the last real command
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			h_new  <= 1'b0;
			h_cnt  <= 5'h00;
			h_last <= sdcc_pkg::CMD_NOP;
		end
		else
		begin
			h_new <= ce && rise;
			if (h_new && sd_cmd != sdcc_pkg::CMD_NOP)
			begin
				h_cnt  <= 5'h00;
				h_last <= sd_cmd;
			end
			else if (h_new && h_cnt != 5'h1F)
				h_cnt <= h_cnt + 5'h01;
		end
	end

	assign iss = ce && rise && s_q.st == sdcc_pkg::ST_IDLE && !ref_req && acc_valid;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	AST_NOP_MODE: assert property (iss && s_q.mode == sdcc_pkg::MODE_NOP
		|=> sd_cmd == sdcc_pkg::CMD_NOP && acc_done) else $error("NOP mode issued command");
	AST_PALL_MODE: assert property (iss && s_q.mode == sdcc_pkg::MODE_PALL
		|=> sd_cmd == sdcc_pkg::CMD_PALL && sd_addr[sdcc_pkg::AP_BIT]) else $error("no precharge");
	AST_LMR_MODE: assert property (iss && s_q.mode == sdcc_pkg::MODE_LMR
		|=> sd_cmd == sdcc_pkg::CMD_LMR && sd_addr == (13'($past(cfg_cas)) << sdcc_pkg::LM_CAS))
		else $error("bad mode register load");
	AST_EMR_MODE: assert property (iss && s_q.mode == sdcc_pkg::MODE_EMR
		|=> sd_cmd == sdcc_pkg::CMD_EMR && sd_bank == sdcc_pkg::BA_EMR) else $error("bad ext load");
	AST_NORMAL_ACT: assert property (iss && s_q.mode == sdcc_pkg::MODE_NORMAL && !s_q.da
		|=> s_q.st == sdcc_pkg::ST_DEC ##[1:40] sd_cmd == sdcc_pkg::CMD_ACT) else $error("no activate");
	AST_DPD_ENTRY: assert property (ce && rise && s_q.st == sdcc_pkg::ST_IDLE && !ref_req
		&& !acc_valid && low_power_config == sdcc_pkg::LOW_POWER_CONFIG_DPD |=> sd_cmd == sdcc_pkg::CMD_DPD && !sd_cke)
		else $error("deep power-down not entered");
	AST_DPD_MODE: assert property (iss && s_q.mode == sdcc_pkg::MODE_DPD
		|=> !sd_cke [*2]) else $error("deep power-down mode ignored");
	AST_ACTIVATE_TO_ACCESS_CYCLES: assert property (h_new && (sd_cmd == sdcc_pkg::CMD_RD || sd_cmd == sdcc_pkg::CMD_WR)
		|-> h_last == sdcc_pkg::CMD_ACT && h_cnt == {1'b0, activate_to_access_cycles}) else $error("activate gap wrong");
	AST_TRP: assert property (h_new && sd_cmd != sdcc_pkg::CMD_NOP
		&& h_last == sdcc_pkg::CMD_PALL |-> h_cnt >= {1'b0, precharge_delay_cycles}) else $error("precharge gap short");
	AST_TRC: assert property (h_new && sd_cmd == sdcc_pkg::CMD_ACT
		&& h_last == sdcc_pkg::CMD_AREF |-> h_cnt >= {1'b0, refresh_to_activate_cycles}) else $error("refresh gap short");
	AST_TWR: assert property (h_new && sd_cmd == sdcc_pkg::CMD_PALL
		&& h_last == sdcc_pkg::CMD_WR |-> h_cnt >= {1'b0, write_recovery_cycles}) else $error("write recovery short");
	AST_ISR_CLR: assert property (ce && acc_ph && !pwrite && paddr == sdcc_pkg::OFS_ISTA
		&& !ref_err |=> !s_q.res) else $error("status read did not clear");

	COV_WRITE: cover property (h_new && sd_cmd == sdcc_pkg::CMD_WR);
	COV_REFRESH: cover property (h_new && sd_cmd == sdcc_pkg::CMD_AREF);
	COV_DPD: cover property (h_new && sd_cmd == sdcc_pkg::CMD_DPD);
	COV_REF_ERR: cover property (ref_err);
endmodule

// >>> bench/sdcc_mem_model.sv
`timescale 1ns/1ps
module sdcc_mem_model (
	input  wire sdcc_pkg::sdcc_cmd_t sd_cmd,
	input  wire logic                sd_cke,
	input  wire logic [1:0]          sd_bank,
	input  wire logic [12:0]         sd_addr,
	output logic                     sd_link_clk
);
	int          n [16] = '{default: 0};
	int          nreal  = 0;
	int          bad_seq = 0;
	logic        banks_idle = 1'b1;
	logic [1:0]  bank_q;
	logic [12:0] addr_q;
	// ***********************************************************
	// memory clock
	// ***********************************************************
	// free-running, phase unrelated to mclk
	initial
	begin
		sd_link_clk = 1'b0;
		#3;
		forever #16 sd_link_clk = ~sd_link_clk;
	end
	// ***********************************************************
	// command capture
	// ***********************************************************
	// sampled on the memory clock, as the device would
	always @(posedge sd_link_clk)
	begin
		n[sd_cmd]++;
		if (sd_cmd != sdcc_pkg::CMD_NOP)
		begin
			nreal++;
			bank_q = sd_bank;
			addr_q = sd_addr;
		end
		if (sd_cmd == sdcc_pkg::CMD_PALL)
			banks_idle = 1'b1;
		if (sd_cmd == sdcc_pkg::CMD_ACT)
			banks_idle = 1'b0;
		// refresh into an open row corrupts it
		if (sd_cmd == sdcc_pkg::CMD_AREF && !banks_idle)
			bad_seq++;
		// once powered down only a fresh init may follow
		if (sd_cmd != sdcc_pkg::CMD_NOP && sd_cmd != sdcc_pkg::CMD_DPD && !sd_cke)
			bad_seq++;
	end
endmodule

// >>> bench/tb_sdram_command_config_regs.sv
`timescale 1ns/1ps
module tb_sdram_command_config_regs;
	logic        mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic        pready, pslverr, acc_valid = 1'b0, acc_write = 1'b0, acc_done, sd_link_clk;
	logic        sd_cke, cfg_bank4, cfg_bus16, err;
	logic [25:0] acc_addr = 26'h0000000;
	logic [1:0]  sd_bank, cfg_cas;
	logic [12:0] sd_addr;
	logic [3:0]  cfg_col_bits, cfg_row_bits;
	logic [31:0] v;
	sdcc_pkg::sdcc_cmd_t sd_cmd;
	int          bad_count = 0, checks = 0, c0;
	sdcc_pkg::sdcc_mode_t md [6] = '{sdcc_pkg::MODE_NOP, sdcc_pkg::MODE_PALL,
		sdcc_pkg::MODE_AREF, sdcc_pkg::MODE_LMR, sdcc_pkg::MODE_EMR, sdcc_pkg::MODE_DPD};
	sdcc_pkg::sdcc_cmd_t ec [6] = '{sdcc_pkg::CMD_NOP, sdcc_pkg::CMD_PALL,
		sdcc_pkg::CMD_AREF, sdcc_pkg::CMD_LMR, sdcc_pkg::CMD_EMR, sdcc_pkg::CMD_DPD};
	// ***********************************************************
	// clock, design and memory
	// ***********************************************************
	always #2 mclk = ~mclk;
	sdcc_ctrl u_dut (.mclk(mclk), .srst(srst), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
		.acc_done(acc_done), .sd_link_clk(sd_link_clk), .sd_cke(sd_cke), .sd_cmd(sd_cmd),
		.sd_bank(sd_bank), .sd_addr(sd_addr), .cfg_col_bits(cfg_col_bits),
		.cfg_row_bits(cfg_row_bits), .cfg_bank4(cfg_bank4), .cfg_bus16(cfg_bus16),
		.cfg_cas(cfg_cas));
	sdcc_mem_model u_mem (.sd_cmd(sd_cmd), .sd_cke(sd_cke), .sd_bank(sd_bank),
		.sd_addr(sd_addr), .sd_link_clk(sd_link_clk));
	// ***********************************************************
	// tasks
	// ***********************************************************
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// setup then access, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge: psel never drops and rises in one step, and writes have landed
		@(posedge mclk);
	endtask
	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(nm, exp, rd);
	endtask
	// level request held until the done pulse, bounded wait
	task access(input logic w);
		int t;
		acc_valid <= 1'b1;
		acc_write <= w;
		t = 0;
		do
		begin
			@(posedge mclk);
			t++;
		end
		while (acc_done !== 1'b1 && t < 3000);
		acc_valid <= 1'b0;
		chk("acc_done", 32'h1, {31'h0, acc_done});
		repeat (24) @(posedge mclk);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ***********************************************************
	// tests
	// ***********************************************************
	// watchdog at 25000 cycles, well beyond the expected run of under 2000 cycles
	initial
	begin
		#100000;
		bad_count++;
		test_done();
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rdchk("cfg reset", sdcc_pkg::OFS_CFG, sdcc_pkg::RST_CFG);
		chk("reset decode", 32'h8B021, {cfg_col_bits, cfg_row_bits, 3'h0, cfg_bank4,
			2'h0, cfg_cas, 3'h0, cfg_bus16});
		rdchk("mode reset", sdcc_pkg::OFS_MODE, 32'h0);
		repeat (400) @(posedge mclk);
		chk("no refresh", 32'h0, u_mem.n[sdcc_pkg::CMD_AREF]);
		apb(1'b1, sdcc_pkg::OFS_RTIM, 32'h00000014);
		repeat (300) @(posedge mclk);
		chk("refresh run", 32'h1, {31'h0, u_mem.n[sdcc_pkg::CMD_AREF] > 0});
		rdchk("refresh err", sdcc_pkg::OFS_ISTA, 32'h1);
		apb(1'b1, sdcc_pkg::OFS_RTIM, 32'h00000FFF);
		repeat (300) @(posedge mclk);
		apb(1'b0, sdcc_pkg::OFS_ISTA, 32'h0);
		rdchk("err cleared", sdcc_pkg::OFS_ISTA, 32'h0);
		// geometry and latency codes
		for (int i = 0; i < 4; i++)
		begin
			v = sdcc_pkg::RST_CFG;
			v[7:0] = {i[0], 2'((i % 3) + 1), i[0], 2'(i % 3), 2'(i)};
			apb(1'b1, sdcc_pkg::OFS_CFG, v);
			chk("col bits", 32'(8 + i), {28'h0, cfg_col_bits});
			chk("row bits", 32'(11 + i % 3), {28'h0, cfg_row_bits});
			chk("banks", {31'h0, i[0]}, {31'h0, cfg_bank4});
			chk("cas", 32'((i % 3) + 1), {30'h0, cfg_cas});
			chk("bus16", {31'h0, i[0]}, {31'h0, cfg_bus16});
		end
		apb(1'b1, sdcc_pkg::OFS_CFG, sdcc_pkg::RST_CFG);
		rdchk("cfg rw", sdcc_pkg::OFS_CFG, sdcc_pkg::RST_CFG);
		// register access kinds and an unmapped place
		apb(1'b1, sdcc_pkg::OFS_IMSK, 32'hFFFFFFFF);
		rdchk("mask ro", sdcc_pkg::OFS_IMSK, 32'h0);
		apb(1'b1, sdcc_pkg::OFS_IEN, 32'h1);
		rdchk("mask set", sdcc_pkg::OFS_IMSK, 32'h1);
		rdchk("ien wo", sdcc_pkg::OFS_IEN, 32'h0);
		apb(1'b1, sdcc_pkg::OFS_IDIS, 32'h1);
		rdchk("mask clr", sdcc_pkg::OFS_IMSK, 32'h0);
		rdchk("unmapped", 8'h28, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		// normal write access walks activate and precharge
		c0 = u_mem.n[sdcc_pkg::CMD_ACT];
		access(1'b1);
		chk("act seen", 32'(c0 + 1), u_mem.n[sdcc_pkg::CMD_ACT]);
		// forced commands, deep power-down last
		apb(1'b1, sdcc_pkg::OFS_LPR, 32'h00000650);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, sdcc_pkg::OFS_MODE, {29'h0, md[i]});
			c0 = (i == 0) ? u_mem.nreal : u_mem.n[ec[i]];
			access(1'b0);
			if (i == 0)
				chk("nop only", 32'(c0), u_mem.nreal);
			else
				chk("forced cmd", 32'(c0 + 1), u_mem.n[ec[i]]);
			if (i == 3)
				chk("lmr cas", 32'h2, {29'h0, u_mem.addr_q[6:4]});
			if (i == 4)
				chk("emr op", 32'h135, {23'h0, u_mem.bank_q, u_mem.addr_q[6:0]});
		end
		chk("dpd cke", 32'h0, {31'h0, sd_cke});
		apb(1'b1, sdcc_pkg::OFS_MODE, 32'h0);
		repeat (24) @(posedge mclk);
		chk("dpd exit", 32'h1, {31'h0, sd_cke});
		apb(1'b1, sdcc_pkg::OFS_LPR, 32'h00000003);
		repeat (24) @(posedge mclk);
		chk("lp dpd", 32'h0, {31'h0, sd_cke});
		apb(1'b1, sdcc_pkg::OFS_LPR, 32'h0);
		repeat (24) @(posedge mclk);
		chk("order", 32'h0, u_mem.bad_seq);
		test_done();
	end
endmodule
